// ==== rtl/bcl_pkg.sv ====
package bcl_pkg;

    // ==========================================================
    // Configuration image layout
    localparam logic [7:0] SIG0_ADDR     = 8'h00;
    localparam logic [7:0] SIG1_ADDR     = 8'h01;
    localparam logic [7:0] APM_ADDR      = 8'h02;
    localparam logic [7:0] RSVD_ADDR     = 8'h03;
    localparam logic [7:0] VCS_ADDR      = 8'h04;
    localparam logic [7:0] OPT_ADDR      = 8'h05;
    localparam logic [7:0] LAST_ADDR     = 8'h05;
    localparam logic [7:0] SIG0_VALUE    = 8'h53;
    localparam logic [7:0] SIG1_VALUE    = 8'h4b;
    localparam logic [7:0] APM_NONE      = 8'h00;

    // ==========================================================
    // Option byte fields
    localparam int OPT_MODE_PAGE8_BIT    = 5;
    localparam int OPT_POLL_STATUS_BIT   = 4;
    localparam int OPT_BUSY_DELAY_BIT    = 3;
    localparam int OPT_SHORT_PKT_BIT     = 2;

    // ==========================================================
    // Built-in defaults
    localparam logic [7:0] DEF_APM       = 8'h00;
    localparam logic [7:0] DEF_VCS       = 8'h24;
    localparam logic [7:0] DEF_OPT       = 8'h07;

    // ==========================================================
    // Memory straps and timing
    localparam logic [2:0] MEM_ADDR_A    = 3'h2;
    localparam logic [2:0] MEM_ADDR_B    = 3'h4;
    localparam int         CLK_MHZ       = 200;
    localparam int         BUSY_DELAY_MS = 120;
    localparam int         BUSY_DELAY_CYC = BUSY_DELAY_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_REQ  = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } bcl_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] auto_power_mgmt_value;
        logic [7:0] vendor_command_signature;
        logic       mode_page8_en;
        logic       poll_status;
        logic       busy_delay_en;
        logic       short_pkt_before_stall;
    } bcl_cfg_t;

endpackage : bcl_pkg

// ==== rtl/bcl_delay_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcl_delay_timer #(
    parameter int unsigned LIMIT = bcl_pkg::BUSY_DELAY_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    input  wire logic cancel,
    // Status
    output logic      busy
);
    logic [31:0] cnt_r;

    assign busy = (cnt_r != 32'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 32'h0;
        end else if (cancel) begin
            cnt_r <= 32'h0;
        end else if (start) begin
            cnt_r <= LIMIT;
        end else if (busy) begin
            cnt_r <= cnt_r - 32'h1;
        end
    end
endmodule : bcl_delay_timer
`default_nettype wire

// ==== rtl/bcl_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcl_loader #(
    parameter int unsigned BUSY_DELAY_CYC = bcl_pkg::BUSY_DELAY_CYC
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Memory read port
    output logic                  mem_rd_req,
    output logic [2:0]            mem_dev_addr,
    output logic [7:0]            mem_byte_addr,
    input  wire logic             mem_rd_ack,
    input  wire logic [7:0]       mem_rd_data,
    input  wire logic             mem_present,
    input  wire logic             mem_strap_alt,
    // Drive initialisation
    input  wire logic             drv_init,
    input  wire logic             drv_is_atapi,
    input  wire logic             drv_apm_supported,
    output logic                  apm_cmd_req,
    output logic [7:0]            apm_cmd_value,
    // Command block decode
    input  wire logic             cb_valid,
    input  wire logic [7:0]       cb_byte0,
    output logic                  cb_is_vendor,
    // Data request check
    input  wire logic             drq_read,
    input  wire logic             len_mismatch,
    input  wire logic             drv_status_valid,
    output logic                  drq_hold,
    // Option outputs
    output bcl_pkg::bcl_cfg_t     cfg,
    output logic                  cfg_done
);
    // ==========================================================
    // Load sequencer
    bcl_pkg::bcl_state_t state_r, state_nxt;
    logic [7:0]          addr_r, addr_nxt;
    logic [7:0]          sig0_r, sig1_r, apm_r, vcs_r, opt_r;
    logic                ack_s1_r, ack_s2_r, ack_prev_r;
    logic                ack_rise;
    logic                last_byte;
    logic                sig_ok;

    assign ack_rise      = ack_s2_r & ~ack_prev_r;
    assign last_byte     = (addr_r == bcl_pkg::LAST_ADDR);
    assign mem_rd_req    = (state_r == bcl_pkg::ST_REQ) & mem_present;
    assign mem_byte_addr = addr_r;
    assign mem_dev_addr  = mem_strap_alt ? bcl_pkg::MEM_ADDR_B : bcl_pkg::MEM_ADDR_A;
    assign cfg_done      = (state_r == bcl_pkg::ST_DONE);
    assign sig_ok        = (sig0_r == bcl_pkg::SIG0_VALUE) &
                           (sig1_r == bcl_pkg::SIG1_VALUE);

    always_comb begin
        state_nxt = state_r;
        addr_nxt  = addr_r;
        case (state_r)
            bcl_pkg::ST_REQ: begin
                if (!mem_present) begin
                    state_nxt = bcl_pkg::ST_DONE;
                end else begin
                    state_nxt = bcl_pkg::ST_WAIT;
                end
            end
            bcl_pkg::ST_WAIT: begin
                if (ack_rise) begin
                    if (last_byte) begin
                        state_nxt = bcl_pkg::ST_DONE;
                    end else begin
                        addr_nxt  = addr_r + 8'h01;
                        state_nxt = bcl_pkg::ST_REQ;
                    end
                end
            end
            bcl_pkg::ST_DONE: begin
                state_nxt = bcl_pkg::ST_DONE;
            end
            default: begin
                state_nxt = bcl_pkg::ST_REQ;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= bcl_pkg::ST_REQ;
            addr_r     <= bcl_pkg::SIG0_ADDR;
            ack_s1_r   <= 1'b0;
            ack_s2_r   <= 1'b0;
            ack_prev_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            addr_r     <= addr_nxt;
            ack_s1_r   <= mem_rd_ack;
            ack_s2_r   <= ack_s1_r;
            ack_prev_r <= ack_s2_r;
        end
    end

    // ==========================================================
    // Byte capture
    logic [7:0] data_s1_r, data_s2_r;
    logic       cap;

    assign cap = (state_r == bcl_pkg::ST_WAIT) & ack_rise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_s1_r <= 8'h00;
            data_s2_r <= 8'h00;
            sig0_r    <= 8'h00;
            sig1_r    <= 8'h00;
            apm_r     <= bcl_pkg::DEF_APM;
            vcs_r     <= bcl_pkg::DEF_VCS;
            opt_r     <= bcl_pkg::DEF_OPT;
        end else begin
            data_s1_r <= mem_rd_data;
            data_s2_r <= data_s1_r;
            if (cap) begin
                case (addr_r)
                    bcl_pkg::SIG0_ADDR: sig0_r <= data_s2_r;
                    bcl_pkg::SIG1_ADDR: sig1_r <= data_s2_r;
                    bcl_pkg::APM_ADDR:  apm_r  <= data_s2_r;
                    bcl_pkg::VCS_ADDR:  vcs_r  <= data_s2_r;
                    bcl_pkg::OPT_ADDR:  opt_r  <= data_s2_r;
                    default:            sig0_r <= sig0_r;
                endcase
            end
        end
    end

    // ==========================================================
    // Applied configuration
    logic     use_img;
    bcl_pkg::bcl_cfg_t cfg_r;

    assign use_img = cfg_done & sig_ok;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
        end else begin
            cfg_r.valid                    <= cfg_done;
            cfg_r.auto_power_mgmt_value    <= use_img ? apm_r : bcl_pkg::DEF_APM;
            cfg_r.vendor_command_signature <= use_img ? vcs_r : bcl_pkg::DEF_VCS;
            cfg_r.mode_page8_en            <= use_img ? opt_r[bcl_pkg::OPT_MODE_PAGE8_BIT]
                                                      : bcl_pkg::DEF_OPT[bcl_pkg::OPT_MODE_PAGE8_BIT];
            cfg_r.poll_status              <= use_img ? opt_r[bcl_pkg::OPT_POLL_STATUS_BIT]
                                                      : bcl_pkg::DEF_OPT[bcl_pkg::OPT_POLL_STATUS_BIT];
            cfg_r.busy_delay_en            <= use_img ? opt_r[bcl_pkg::OPT_BUSY_DELAY_BIT]
                                                      : bcl_pkg::DEF_OPT[bcl_pkg::OPT_BUSY_DELAY_BIT];
            cfg_r.short_pkt_before_stall   <= use_img ? opt_r[bcl_pkg::OPT_SHORT_PKT_BIT]
                                                      : bcl_pkg::DEF_OPT[bcl_pkg::OPT_SHORT_PKT_BIT];
        end
    end

    assign cfg = cfg_r;

    // ==========================================================
    // Power management request
    logic       apm_go;
    logic       apm_req_r;
    logic [7:0] apm_val_r;

    assign apm_go = cfg_r.valid & drv_init & ~drv_is_atapi & drv_apm_supported
                    & (cfg_r.auto_power_mgmt_value != bcl_pkg::APM_NONE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            apm_req_r <= 1'b0;
            apm_val_r <= 8'h00;
        end else begin
            apm_req_r <= apm_go;
            apm_val_r <= apm_go ? cfg_r.auto_power_mgmt_value : apm_val_r;
        end
    end

    assign apm_cmd_req   = apm_req_r;
    assign apm_cmd_value = apm_val_r;

    // ==========================================================
    // Vendor command decode
    logic vend_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vend_r <= 1'b0;
        end else begin
            vend_r <= cb_valid & cfg_r.valid
                      & (cb_byte0 == cfg_r.vendor_command_signature);
        end
    end

    assign cb_is_vendor = vend_r;

    // ==========================================================
    // Busy bit delay
    logic tmr_busy;
    logic tmr_start;

    assign tmr_start = drq_read & len_mismatch & cfg_r.busy_delay_en & ~tmr_busy;
    assign drq_hold  = tmr_busy & ~drv_status_valid;

    bcl_delay_timer #(
        .LIMIT (BUSY_DELAY_CYC)
    ) u_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (tmr_start),
        .cancel (drv_status_valid),
        .busy   (tmr_busy)
    );

endmodule : bcl_loader
`default_nettype wire

// ==== verif/bcl_loader_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcl_loader_monitor #(
    parameter int unsigned BUSY_DELAY_CYC = bcl_pkg::BUSY_DELAY_CYC
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Memory side
    input wire logic [2:0]        mem_dev_addr,
    input wire logic [7:0]        mem_byte_addr,
    input wire logic              mem_strap_alt,
    // Drive and command side
    input wire logic              drv_init,
    input wire logic              drv_is_atapi,
    input wire logic              drv_apm_supported,
    input wire logic              apm_cmd_req,
    input wire logic [7:0]        apm_cmd_value,
    input wire logic              cb_valid,
    input wire logic [7:0]        cb_byte0,
    input wire logic              cb_is_vendor,
    input wire logic              drq_hold,
    // Options
    input wire bcl_pkg::bcl_cfg_t cfg,
    input wire logic              cfg_done
);
    // ==========================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_STRAP: assert property (mem_dev_addr == (mem_strap_alt ? 3'h4 : 3'h2))
        else $error("device address does not follow strap");
    AST_ORDER: assert property ($changed(mem_byte_addr) |-> mem_byte_addr == $past(mem_byte_addr) + 8'h01)
        else $error("byte address not ascending");
    AST_DONE_VALID: assert property ($rose(cfg_done) |=> cfg.valid)
        else $error("options not valid after load");
    AST_DONE_STAYS: assert property (cfg_done |=> cfg_done)
        else $error("load finished flag dropped");
    AST_APM: assert property (drv_init && !drv_is_atapi && drv_apm_supported && cfg.valid
        && cfg.auto_power_mgmt_value != 8'h00 |=> apm_cmd_req && apm_cmd_value == $past(cfg.auto_power_mgmt_value))
        else $error("power management request missing");
    AST_APM_ZERO: assert property (drv_init && cfg.auto_power_mgmt_value == 8'h00 |=> !apm_cmd_req)
        else $error("power management request with zero value");
    AST_ATAPI: assert property (drv_is_atapi |=> !apm_cmd_req)
        else $error("power management request for packet device");
    AST_APM_UNSUP: assert property (!drv_apm_supported |=> !apm_cmd_req)
        else $error("power management request without device support");
    AST_VENDOR: assert property (cb_valid && cfg.valid |=> cb_is_vendor == ($past(cb_byte0) == $past(cfg.vendor_command_signature)))
        else $error("vendor command decode wrong");
    AST_NOHOLD: assert property (!cfg.busy_delay_en |-> !drq_hold)
        else $error("busy delay active while disabled");
endmodule : bcl_loader_monitor
bind bcl_loader bcl_loader_monitor #(.BUSY_DELAY_CYC(BUSY_DELAY_CYC)) bcl_loader_monitor_inst (
    .clk(clk), .rst_n(rst_n), .mem_dev_addr(mem_dev_addr), .mem_byte_addr(mem_byte_addr),
    .mem_strap_alt(mem_strap_alt), .drv_init(drv_init), .drv_is_atapi(drv_is_atapi),
    .drv_apm_supported(drv_apm_supported), .apm_cmd_req(apm_cmd_req), .apm_cmd_value(apm_cmd_value),
    .cb_valid(cb_valid), .cb_byte0(cb_byte0), .cb_is_vendor(cb_is_vendor), .drq_hold(drq_hold),
    .cfg(cfg), .cfg_done(cfg_done));
`default_nettype wire

// ==== verif/bcl_eeprom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcl_eeprom_model (
    // Clock and setup
    input  wire logic        clk,
    input  wire logic [2:0]  strap,
    input  wire logic [47:0] image,
    input  wire logic [3:0]  dly,
    // Read port
    input  wire logic        rd_req,
    input  wire logic [2:0]  dev_addr,
    input  wire logic [7:0]  byte_addr,
    output logic             ack,
    output logic [7:0]       data
);
    logic [7:0] n_req  = 8'h00;
    logic [7:0] n_done = 8'h00;
    logic [7:0] pa     = 8'h00;
    // ==========================================================
    // Request capture, only at its own strap address
    always @(posedge clk) if (rd_req && dev_addr === strap) begin
        n_req <= n_req + 8'h01;
        pa    <= byte_addr;
    end
    // Answer: data first, ack later, then data lost
    initial begin
        ack  = 1'b0;
        data = 8'h00;
        forever begin
            @(posedge clk);
            if (n_req != n_done) begin
                n_done <= n_done + 8'h01;
                repeat (dly) @(posedge clk);
                data <= (pa > 8'h05) ? 8'h00 : image[8*(5-pa) +: 8];
                repeat (3) @(posedge clk);
                ack <= 1'b1;
                repeat (2) @(posedge clk);
                ack <= 1'b0;
                repeat (4) @(posedge clk);
                data <= ~data;
            end
        end
    end
endmodule : bcl_eeprom_model
`default_nettype wire

// ==== verif/bridge_eeprom_config_loader_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bridge_eeprom_config_loader_tb;
    typedef struct {
        logic              p;
        logic              alt;
        logic [3:0]        dly;
        logic [47:0]       img;
        bcl_pkg::bcl_cfg_t exp;
    } bcl_row_t;
    localparam bcl_pkg::bcl_cfg_t DEF = {1'b1, 8'h00, 8'h24, 4'b0001};
    logic clk = 1'b0, rst_n = 1'b0, mem_present = 1'b0, mem_strap_alt = 1'b0;
    logic drv_init = 1'b0, drv_is_atapi = 1'b0, drv_apm_supported = 1'b0, cb_valid = 1'b0;
    logic drq_read = 1'b0, len_mismatch = 1'b0, drv_status_valid = 1'b0;
    logic [7:0] cb_byte0 = 8'h00, mem_rd_data, mem_byte_addr, apm_cmd_value;
    logic [47:0] img = '0;
    logic [3:0] dly = 4'h1;
    logic [2:0] mem_dev_addr;
    logic mem_rd_ack, mem_rd_req, apm_cmd_req, cb_is_vendor, drq_hold, cfg_done;
    bcl_pkg::bcl_cfg_t cfg;
    int n_errors = 0, total_checks = 0, i, k;
    bcl_row_t rows[5];
    always #2.5 clk = ~clk;
    bcl_loader #(.BUSY_DELAY_CYC(50)) bcl_loader_inst (.clk(clk), .rst_n(rst_n),
        .mem_rd_req(mem_rd_req), .mem_dev_addr(mem_dev_addr), .mem_byte_addr(mem_byte_addr),
        .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .mem_present(mem_present),
        .mem_strap_alt(mem_strap_alt), .drv_init(drv_init), .drv_is_atapi(drv_is_atapi),
        .drv_apm_supported(drv_apm_supported), .apm_cmd_req(apm_cmd_req),
        .apm_cmd_value(apm_cmd_value), .cb_valid(cb_valid), .cb_byte0(cb_byte0),
        .cb_is_vendor(cb_is_vendor), .drq_read(drq_read), .len_mismatch(len_mismatch),
        .drv_status_valid(drv_status_valid), .drq_hold(drq_hold), .cfg(cfg), .cfg_done(cfg_done));
    bcl_eeprom_model bcl_eeprom_model_inst (.clk(clk), .strap(mem_strap_alt ? 3'h4 : 3'h2),
        .image(img), .dly(dly), .rd_req(mem_rd_req), .dev_addr(mem_dev_addr),
        .byte_addr(mem_byte_addr), .ack(mem_rd_ack), .data(mem_rd_data));
    // ==========================================================
    // Helpers
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic load(input int r, input bit cut);
        @(posedge clk);
        {mem_strap_alt, dly, img, mem_present, rst_n} <= {rows[r].alt, rows[r].dly, rows[r].img, 2'b00};
        repeat (3) @(posedge clk);
        chk(cfg, '0);
        chk({cfg_done, mem_rd_req}, 2'b00);
        {rst_n, mem_present} <= {1'b1, rows[r].p};
        if (cut) begin
            repeat (12) @(posedge clk);
            {rst_n, mem_present} <= 2'b00;
            repeat (20) @(posedge clk);
            {rst_n, mem_present} <= {1'b1, rows[r].p};
        end
        for (k = 0; k < 400 && cfg_done !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        chk(cfg, rows[r].exp);
    endtask : load
    task automatic use_cfg(input bcl_pkg::bcl_cfg_t e);
        @(posedge clk);
        {drv_init, drv_is_atapi, drv_apm_supported, cb_valid, cb_byte0} <= {4'b1011, e.vendor_command_signature};
        @(posedge clk);
        {drv_is_atapi, cb_byte0} <= {1'b1, ~e.vendor_command_signature};
        @(negedge clk);
        chk(apm_cmd_req ? apm_cmd_value : 8'h00, e.auto_power_mgmt_value);
        chk(cb_is_vendor, 1'b1);
        @(posedge clk);
        {drv_init, cb_valid, drq_read, len_mismatch} <= 4'b0011;
        @(negedge clk);
        chk({apm_cmd_req, cb_is_vendor}, 2'b00);
        @(posedge clk) drq_read <= 1'b0;
        repeat (3) @(negedge clk);
        chk(drq_hold, e.busy_delay_en);
        @(posedge clk) {drv_status_valid, len_mismatch} <= 2'b10;
        repeat (2) @(negedge clk);
        chk(drq_hold, 1'b0);
        @(posedge clk) drv_status_valid <= 1'b0;
    endtask : use_cfg
    // ==========================================================
    // Sequence
    initial begin
        rows = '{'{1'b1, 1'b0, 4'h1, 48'h534b5a00a728, {1'b1, 8'h5a, 8'ha7, 4'b1010}},
                 '{1'b1, 1'b1, 4'h6, 48'h534b00003c14, {1'b1, 8'h00, 8'h3c, 4'b0101}},
                 '{1'b1, 1'b0, 4'h1, 48'h524b5a00a728, DEF},
                 '{1'b1, 1'b1, 4'h3, 48'h534a5a00a728, DEF},
                 '{1'b0, 1'b0, 4'h1, 48'h534b5a00a728, DEF}};
        for (i = 0; i < 5; i++) begin
            load(i, 1'b0);
            use_cfg(rows[i].exp);
        end
        // Busy delay runs out without status, and needs a length mismatch
        load(0, 1'b0);
        @(posedge clk) drq_read <= 1'b1;
        @(posedge clk) {drq_read, len_mismatch} <= 2'b11;
        @(negedge clk);
        chk(drq_hold, 1'b0);
        @(posedge clk) drq_read <= 1'b0;
        repeat (20) @(negedge clk);
        chk(drq_hold, 1'b1);
        repeat (40) @(negedge clk);
        chk(drq_hold, 1'b0);
        @(posedge clk) {len_mismatch, drv_init, drv_is_atapi, drv_apm_supported} <= 4'b0100;
        repeat (2) @(negedge clk);
        chk(apm_cmd_req, 1'b0);
        @(posedge clk) drv_init <= 1'b0;
        // Reset in the middle of a load, then a clean reload
        load(1, 1'b1);
        close_out();
    end
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule : bridge_eeprom_config_loader_tb
`default_nettype wire
